//--- verif/ntbms_csr_monitor.sv
// Port checker for the window setup CSR block
`timescale 1ns/1ps
module ntbms_csr_monitor #(parameter AW = 12) (
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Primary and secondary ports
  input wire pri_req,
  input wire pri_we,
  input wire [AW-1:0] pri_addr,
  input wire pri_ready,
  input wire pri_ack,
  input wire [31:0] pri_rdata,
  input wire sec_req,
  input wire sec_ready,
  input wire sec_ack,
  // Translation and window state
  input wire [1:0] ds_hit,
  input wire [63:0] ds_addr,
  input wire [1:0] ds_out_valid,
  input wire [63:0] ds_out_addr,
  input wire [31:0] ds2_bar_mask,
  input wire [31:0] us3_bar_mask,
  input wire [3:0] win_en,
  input wire [2:0] win_is64
);
  // Reserved offsets, both ranges
  wire rsv_hit = (pri_addr <= 12'h004) || (pri_addr >= 12'h01C && pri_addr <= 12'h030);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);
  sequence s_take; pri_req && pri_ready; endsequence
  sequence s_pulse; pri_ack ##1 !pri_ack; endsequence
  sequence s_rsv_rd; pri_req && pri_ready && !pri_we && rsv_hit; endsequence
  AST_PRI_ACK: assert property (s_take |=> s_pulse)
    else $error("primary answer is not one pulse");
  AST_ACK_CAUSE: assert property (pri_ack |-> $past(pri_req) && $past(pri_ready))
    else $error("primary answer without request");
  AST_SEC_ACK: assert property (sec_req && sec_ready |=> sec_ack && !sec_ready)
    else $error("secondary answer missing");
  AST_SEC_YIELD: assert property (pri_req |-> !sec_ready)
    else $error("secondary taken while primary waits");
  AST_RSV_READ: assert property (s_rsv_rd |=> pri_ack && pri_rdata == 32'h0000_0000)
    else $error("reserved offset read nonzero");
  AST_VALID2: assert property (ds_hit[0] |=> ds_out_valid[0] == win_en[0])
    else $error("window 2 valid does not follow enable");
  AST_XLATE2: assert property (ds_hit[0] && win_en[0] |=>
    (ds_out_addr[31:0] & ~ds2_bar_mask) == ($past(ds_addr[31:0]) & ~ds2_bar_mask))
    else $error("window 2 offset bits altered");
  AST_MASK_LOW: assert property (ds2_bar_mask[11:0] == 12'h000 && us3_bar_mask[11:0] == 12'h000)
    else $error("mask low bits set");
  AST_US3_64: assert property ($past(sys_rst) && !sys_rst |=> win_is64[2] && win_en[2])
    else $error("upstream window 3 not 64-bit after reset");
endmodule // ntbms_csr_monitor

bind ntbms_csr ntbms_csr_monitor #(.AW(AW)) i_ntbms_csr_monitor (.*);

//--- verif/ntbms_csr_tb.sv
// Self-checking bench for the window setup CSR block
`timescale 1ns/1ps
module ntbms_csr_tb;
  logic core_clk = 0, sys_rst = 1, hot_rst = 0, pri_req = 0, pri_we = 0, ld_valid = 0;
  logic [11:0] pri_addr = 0;
  logic [3:0] pri_be = 0;
  logic [31:0] pri_wdata = 0, ld_data = 0;
  logic [1:0] ld_sel = 0, ds_hit = 0;
  logic [63:0] ds_addr = 0;
  wire pri_ready, pri_ack, sec_req, sec_we, sec_ready, sec_ack;
  wire [11:0] sec_addr;
  wire [3:0] sec_be, win_en;
  wire [31:0] pri_rdata, sec_wdata, sec_rdata, ds2_bar_mask, ds3_bar_mask, ds3_upper_mask;
  wire [31:0] us3_bar_mask;
  wire [1:0] ds_out_valid;
  wire [63:0] ds_out_addr;
  wire [2:0] win_prefetch, win_is64;
  int bad_count = 0, comparisons = 0;
  logic [31:0] pq[$], sq[$], dq[$];
  logic [11:0] offs[6] = '{12'h008, 12'h00C, 12'h010, 12'h014, 12'h018, 12'h034};
  logic [31:0] rstv[6] = '{0, 0, 0, 0, 0, 32'h0000_0002};

  always #12.5 core_clk = ~core_clk;

  ntbms_csr #(.AW(12)) i_ntbms_csr (.*);
  ntbms_host i_ntbms_host (.core_clk(core_clk), .sec_req(sec_req), .sec_we(sec_we),
    .sec_addr(sec_addr), .sec_be(sec_be), .sec_wdata(sec_wdata), .sec_ready(sec_ready));

  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    comparisons++;
    if (s !== e)
    begin
      bad_count++;
      $display("ERROR %s exp %h seen %h", n, e, s);
    end
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  task automatic timeout;
    bad_count++;
    report_and_stop();
  endtask

  // Primary access; the note is the expected answer data
  task automatic pacc(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e, input logic [3:0] be = 4'hF);
    int n;
    @(posedge core_clk);
    pq.push_back(e);
    pri_req <= 1'b1;
    pri_we <= w;
    pri_addr <= a;
    pri_be <= be;
    pri_wdata <= d;
    @(negedge core_clk);
    for (n = 0; pri_ready !== 1'b1 && n < 60; n++)
      @(negedge core_clk);
    if (n >= 60)
      timeout();
    @(posedge core_clk);
    pri_req <= 1'b0;
    pri_addr <= ~a;
    pri_wdata <= ~d;
  endtask

  task automatic sacc(input logic w, input logic [11:0] a, input logic [31:0] d,
    input logic [31:0] e);
    int n;
    sq.push_back(e);
    i_ntbms_host.access(w, a, d, n);
    if (n >= 60)
      timeout();
  endtask

  // Loader pulse, then time for the registered outputs to settle
  task automatic load(input logic [1:0] s, input logic [31:0] d);
    @(posedge core_clk);
    ld_valid <= 1'b1;
    ld_sel <= s;
    ld_data <= d;
    @(posedge core_clk);
    ld_valid <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask

  task automatic hit(input int i, input logic [31:0] a, input logic [31:0] e);
    @(posedge core_clk);
    dq.push_back(e);
    ds_hit <= 2'b01 << i;
    ds_addr <= {a, a};
    @(posedge core_clk);
    ds_hit <= 2'b00;
    ds_addr <= ~{a, a};
    repeat (2) @(posedge core_clk);
  endtask

  // Answer watcher, oldest note first
  always @(posedge core_clk)
  begin
    #1;
    if (pri_ack === 1'b1)
      chk("pri_rdata", pri_rdata, pq.size() ? pq.pop_front() : 32'hxxxx_xxxx);
    if (sec_ack === 1'b1)
      chk("sec_rdata", sec_rdata, sq.size() ? sq.pop_front() : 32'hxxxx_xxxx);
    if (ds_out_valid[0] === 1'b1)
      chk("ds2_out", ds_out_addr[31:0], dq.size() ? dq.pop_front() : 32'hxxxx_xxxx);
    if (ds_out_valid[1] === 1'b1)
      chk("ds3_out", ds_out_addr[63:32], dq.size() ? dq.pop_front() : 32'hxxxx_xxxx);
  end

  initial
  begin
    #500000;
    timeout();
  end

  initial
  begin
    logic [31:0] v, m, b, a;
    int i;
    void'($urandom(47269));
    repeat (2) @(posedge core_clk);
    sys_rst <= 1'b0;
    for (i = 0; i < 6; i++)
      pacc(0, offs[i], 0, rstv[i]);
    chk("win_en", 32'(win_en), 32'h0000_0004);
    // Reserved offsets swallow writes; an unmapped offset reads zero
    for (i = 0; i < 8; i++)
    begin
      a = (i < 2) ? i * 4 : 28 + (i - 2) * 4;
      pacc(1, a[11:0], 32'hFFFF_FFFF, 0);
      pacc(0, a[11:0], 0, 0);
    end
    pacc(0, 12'hFFC, 0, 0);
    v = $urandom();
    pacc(1, 12'h008, v, 0);
    pacc(0, 12'h008, 0, v & 32'hFFFF_F000);
    pacc(1, 12'h008, ~v, 0, 4'b0100);
    pacc(0, 12'h008, 0, {v[31:24], ~v[23:16], v[15:12], 12'h000});
    pacc(1, 12'h00C, 32'hFFFF_FFFF, 0);
    pacc(0, 12'h00C, 0, 0);
    // Both downstream windows, enabled, random size
    for (i = 0; i < 2; i++)
    begin
      v = ($urandom() & 32'hFFFF_FFFB) | 32'h8000_0000;
      load(i[1:0], v);
      m = {1'b1, v[30:12], 12'h000};
      pacc(0, i ? 12'h014 : 12'h00C, 0, v & 32'hFFFF_F00E);
      chk("ds_mask", i ? ds3_bar_mask : ds2_bar_mask, m);
      chk("win_en", 32'(win_en[i]), 1);
      chk("win_pf", 32'(win_prefetch[i]), 32'(v[3]));
      chk("win_64", 32'(win_is64[i]), 32'(v[1]));
      b = $urandom();
      pacc(1, i ? 12'h010 : 12'h008, b, 0);
      a = $urandom();
      hit(i, a, (b & m) | (a & ~m));
    end
    // Sized but disabled: no valid, address passes raw
    load(2'd0, 32'h7FFF_F000);
    @(posedge core_clk);
    ds_hit <= 2'b01;
    ds_addr <= {32'h0000_0000, a};
    @(posedge core_clk);
    ds_hit <= 2'b00;
    #1;
    chk("ds2_valid", 32'(ds_out_valid[0]), 0);
    chk("ds2_raw", ds_out_addr[31:0], a);
    sacc(1, 12'h034, 32'hFFFF_FFFF, 0);
    sacc(0, 12'h034, 0, 32'hFFFF_F00A);
    chk("us3_mask", us3_bar_mask, 32'hFFFF_F000);
    chk("us3_pf", 32'(win_prefetch[2]), 1);
    v = $urandom();
    sacc(1, 12'h018, v, 0);
    // Summary outputs trail the register by one edge
    repeat (2) @(posedge core_clk);
    chk("upper_mask", ds3_upper_mask, {1'b0, v[30:0]});
    chk("upper_en", 32'(win_en[3]), 32'(v[31]));
    // Both ports at once; primary goes first
    fork
      pacc(0, 12'h018, 0, v);
      sacc(0, 12'h018, 0, v);
    join
    load(2'd2, 32'h0000_0000);
    pacc(0, 12'h034, 0, 32'hFFFF_F008);
    @(posedge core_clk);
    hot_rst <= 1'b1;
    @(posedge core_clk);
    hot_rst <= 1'b0;
    pacc(0, 12'h018, 0, 0);
    pacc(0, 12'h034, 0, 32'h0000_0002);
    repeat (4) @(posedge core_clk);
    chk("notes_left", 32'(pq.size() + sq.size() + dq.size()), 0);
    report_and_stop();
  end
endmodule // ntbms_csr_tb

//--- verif/ntbms_host.sv
// Host model on the secondary CSR port
`timescale 1ns/1ps
module ntbms_host (
  // Clock
  input wire core_clk,
  // Secondary port
  output logic sec_req = 1'b0,
  output logic sec_we = 1'b0,
  output logic [11:0] sec_addr = 12'h000,
  output logic [3:0] sec_be = 4'h0,
  output logic [31:0] sec_wdata = 32'h0000_0000,
  input wire sec_ready
);
  // One access held until taken; primary traffic may stall it
  task automatic access(input logic w, input logic [11:0] a, input logic [31:0] d, output int n);
    @(posedge core_clk);
    sec_req <= 1'b1;
    sec_we <= w;
    sec_addr <= a;
    sec_be <= 4'hF;
    sec_wdata <= d;
    @(negedge core_clk);
    for (n = 0; sec_ready !== 1'b1 && n < 60; n++)
      @(negedge core_clk);
    @(posedge core_clk);
    sec_req <= 1'b0;
    // Released lines carry junk, not the old value
    sec_addr <= ~a;
    sec_wdata <= ~d;
  endtask
endmodule // ntbms_host

//--- verilog/ntbms_csr.v
// Non-transparent bridge memory window setup and translation-base CSR block
`timescale 1ns/1ps
`include "ntbms_regs.vh"

// How it works
// - Both the primary and the secondary port, memory or I/O, can read and write the CSRs.
// - Fields are read-only or read/write; sticky and write-1-clear classes are defined but no field uses them.
// - Window 2 translated base sits in bits 31:12, bits 11:0 read zero, reset value zero.
// - Base bit 31 and the base bits the window size field selects replace address bits.
// - Window 3 has its own translated base in bits 31:12, sized by its setup, reset zero.
// - Bit 0 of every setup register reads zero, meaning memory space.
// - Address type in bits 2:1 is 00 for 32-bit, 01 for 64-bit, bus read-only downstream.
// - Bit 3 is the prefetchable flag, reset zero, bus-writable only upstream window 3.
// - Downstream size bits 30:12 select which base bits replace address bits, fixing the window size.
// - Bit 31 of a downstream setup register enables the window, reset disabled.
// - Window 3 upper setup is read/write: 30:0 size mask, 31 enables 64-bit base.
// - Upstream window 3 address type is read-only and resets to 64-bit.
// - Upstream window 3 bits 31:12 are a writable size mask, reset zero.
// - Setup bits 11:4 are reserved, read zero.
// - Offsets 01C..030 and 000..004 are reserved with no function.
module ntbms_csr
#(
  parameter AW = 12
)
(
  // Clock and resets
  input wire core_clk,
  input wire sys_rst,
  input wire hot_rst,
  // Primary port CSR access
  input wire pri_req,
  input wire pri_we,
  input wire [AW-1:0] pri_addr,
  input wire [3:0] pri_be,
  input wire [31:0] pri_wdata,
  output wire pri_ready,
  output reg pri_ack,
  output reg [31:0] pri_rdata,
  // Secondary port CSR access
  input wire sec_req,
  input wire sec_we,
  input wire [AW-1:0] sec_addr,
  input wire [3:0] sec_be,
  input wire [31:0] sec_wdata,
  output wire sec_ready,
  output reg sec_ack,
  output reg [31:0] sec_rdata,
  // Setup loader for bus read-only fields
  input wire ld_valid,
  input wire [1:0] ld_sel,
  input wire [31:0] ld_data,
  // Downstream transactions
  input wire [1:0] ds_hit,
  input wire [63:0] ds_addr,
  output wire [1:0] ds_out_valid,
  output wire [63:0] ds_out_addr,
  // Window state for the BAR decoders
  output reg [31:0] ds2_bar_mask,
  output reg [31:0] ds3_bar_mask,
  output reg [31:0] ds3_upper_mask,
  output reg [31:0] us3_bar_mask,
  output reg [3:0] win_en,
  output reg [2:0] win_prefetch,
  output reg [2:0] win_is64
);

  // Field classes of the stored registers
  localparam [2:0] CLS_XBASE = `NTBMS_CLS_RW;
  localparam [2:0] CLS_UPPER = `NTBMS_CLS_RW;
  localparam [2:0] CLS_US3 = `NTBMS_CLS_RW;

  // Access arbitration states (one-hot)
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_RESP = 2'b10;

  // Applies one write to a field according to its class
  function [31:0] cls_write;
    input [2:0] cls;
    input [31:0] old;
    input [31:0] wd;
    input [31:0] bm;
    begin
      case (cls)
        `NTBMS_CLS_RW, `NTBMS_CLS_RWS:
          cls_write = (old & ~bm) | (wd & bm);
        `NTBMS_CLS_RWC, `NTBMS_CLS_RWCS:
          cls_write = old & ~(wd & bm);
        default:
          cls_write = old;
      endcase
    end
  endfunction

  // Hot reset spares the sticky classes only
  function hot_clears;
    input [2:0] cls;
    begin
      case (cls)
        `NTBMS_CLS_ROS, `NTBMS_CLS_RWS, `NTBMS_CLS_RWCS:
          hot_clears = 1'b0;
        default:
          hot_clears = 1'b1;
      endcase
    end
  endfunction

  // Stored fields
  reg [19:0] ds2_xbase_r;
  reg [19:0] ds3_xbase_r;
  reg [1:0] ds2_atype_r;
  reg [1:0] ds3_atype_r;
  reg ds2_pf_r;
  reg ds3_pf_r;
  reg [18:0] ds2_size_r;
  reg [18:0] ds3_size_r;
  reg ds2_en_r;
  reg ds3_en_r;
  reg [31:0] ds3_upper_r;
  reg [1:0] us3_atype_r;
  reg us3_pf_r;
  reg [19:0] us3_size_r;
  reg [1:0] state_r;
  reg [1:0] state_nxt;

  // Selected access and decoded views
  wire acc_valid;
  wire acc_sec;
  wire acc_we;
  wire [AW-1:0] acc_addr;
  wire [31:0] acc_wdata;
  wire [31:0] acc_bm;
  wire [31:0] ds2_setup_v;
  wire [31:0] ds3_setup_v;
  wire [31:0] us3_setup_v;
  wire [31:0] ds2_xbase_v;
  wire [31:0] ds3_xbase_v;
  wire wr_ds2_xb;
  wire wr_ds3_xb;
  wire wr_ds3_up;
  wire wr_us3;
  wire soft_clr;
  reg [31:0] rd_mux;
  // Full-width write results; only the stored field is kept from each
  wire [31:0] ds2_xb_new;
  wire [31:0] ds3_xb_new;
  wire [31:0] us3_new;

  // Primary wins a same-cycle clash; secondary waits one access
  assign pri_ready = (state_r == ST_IDLE);
  assign sec_ready = (state_r == ST_IDLE) & ~pri_req;
  assign acc_sec = ~pri_req;
  assign acc_valid = (state_r == ST_IDLE) & (pri_req | sec_req);
  assign acc_we = acc_sec ? sec_we : pri_we;
  assign acc_addr = acc_sec ? sec_addr : pri_addr;
  assign acc_wdata = acc_sec ? sec_wdata : pri_wdata;
  assign acc_bm = acc_sec ? {{8{sec_be[3]}}, {8{sec_be[2]}}, {8{sec_be[1]}}, {8{sec_be[0]}}}
                          : {{8{pri_be[3]}}, {8{pri_be[2]}}, {8{pri_be[1]}}, {8{pri_be[0]}}};

  // Register views; reserved and read-only-zero bits are constants
  assign ds2_xbase_v = {ds2_xbase_r, 12'h000};
  assign ds3_xbase_v = {ds3_xbase_r, 12'h000};
  assign ds2_setup_v = {ds2_en_r, ds2_size_r, 8'h00, ds2_pf_r, ds2_atype_r, 1'b0};
  assign ds3_setup_v = {ds3_en_r, ds3_size_r, 8'h00, ds3_pf_r, ds3_atype_r, 1'b0};
  assign us3_setup_v = {us3_size_r, 8'h00, us3_pf_r, us3_atype_r, 1'b0};

  // Write strobes; only these offsets take bus writes
  assign wr_ds2_xb = acc_valid & acc_we & (acc_addr == `NTBMS_OFF_DS2_XBASE);
  assign wr_ds3_xb = acc_valid & acc_we & (acc_addr == `NTBMS_OFF_DS3_XBASE);
  assign wr_ds3_up = acc_valid & acc_we & (acc_addr == `NTBMS_OFF_DS3_UPPER);
  assign wr_us3 = acc_valid & acc_we & (acc_addr == `NTBMS_OFF_US3_SETUP);
  assign soft_clr = sys_rst | hot_rst;
  assign ds2_xb_new = cls_write(CLS_XBASE, ds2_xbase_v, acc_wdata, acc_bm);
  assign ds3_xb_new = cls_write(CLS_XBASE, ds3_xbase_v, acc_wdata, acc_bm);
  assign us3_new = cls_write(CLS_US3, us3_setup_v, acc_wdata, acc_bm);

  // Read decode; everything unlisted, reserved ranges included, reads zero
  always @*
  begin
    case (acc_addr)
      `NTBMS_OFF_DS2_XBASE: rd_mux = ds2_xbase_v;
      `NTBMS_OFF_DS2_SETUP: rd_mux = ds2_setup_v;
      `NTBMS_OFF_DS3_XBASE: rd_mux = ds3_xbase_v;
      `NTBMS_OFF_DS3_SETUP: rd_mux = ds3_setup_v;
      `NTBMS_OFF_DS3_UPPER: rd_mux = ds3_upper_r;
      `NTBMS_OFF_US3_SETUP: rd_mux = us3_setup_v;
      default: rd_mux = 32'h0000_0000;
    endcase
  end

  // Next access state
  always @*
  begin
    case (state_r)
      ST_IDLE: state_nxt = acc_valid ? ST_RESP : ST_IDLE;
      ST_RESP: state_nxt = ST_IDLE;
      default: state_nxt = ST_IDLE;
    endcase
  end

  // Access sequencer and answer registers
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      state_r <= ST_IDLE;
      pri_ack <= 1'b0;
      sec_ack <= 1'b0;
      pri_rdata <= 32'h0000_0000;
      sec_rdata <= 32'h0000_0000;
    end
    else
    begin
      state_r <= state_nxt;
      pri_ack <= acc_valid & ~acc_sec;
      sec_ack <= acc_valid & acc_sec;
      // Read data is captured for reads and writes alike; writes return zero
      if (acc_valid & ~acc_sec)
        pri_rdata <= acc_we ? 32'h0000_0000 : rd_mux;
      if (acc_valid & acc_sec)
        sec_rdata <= acc_we ? 32'h0000_0000 : rd_mux;
    end
  end

  // Translated bases, bus read/write
  always @(posedge core_clk)
  begin
    if (soft_clr & hot_clears(CLS_XBASE) | sys_rst)
    begin
      ds2_xbase_r <= `NTBMS_RST_XBASE;
      ds3_xbase_r <= `NTBMS_RST_XBASE;
    end
    else
    begin
      if (wr_ds2_xb)
        ds2_xbase_r <= ds2_xb_new[`NTBMS_XBASE_HI:`NTBMS_XBASE_LO];
      if (wr_ds3_xb)
        ds3_xbase_r <= ds3_xb_new[`NTBMS_XBASE_HI:`NTBMS_XBASE_LO];
    end
  end

  // Downstream setups: bus read-only, filled by the loader only
  always @(posedge core_clk)
  begin
    if (soft_clr)
    begin
      ds2_atype_r <= `NTBMS_RST_ATYPE_DS;
      ds3_atype_r <= `NTBMS_RST_ATYPE_DS;
      ds2_pf_r <= 1'b0;
      ds3_pf_r <= 1'b0;
      ds2_size_r <= `NTBMS_RST_SIZE_DS;
      ds3_size_r <= `NTBMS_RST_SIZE_DS;
      ds2_en_r <= 1'b0;
      ds3_en_r <= 1'b0;
    end
    else if (ld_valid & (ld_sel == `NTBMS_LD_DS2))
    begin
      ds2_atype_r <= ld_data[`NTBMS_SETUP_ATYPE_HI:`NTBMS_SETUP_ATYPE_LO];
      ds2_pf_r <= ld_data[`NTBMS_SETUP_PF_BIT];
      ds2_size_r <= ld_data[`NTBMS_SETUP_SIZE_HI:`NTBMS_SETUP_SIZE_LO];
      ds2_en_r <= ld_data[`NTBMS_SETUP_EN_BIT];
    end
    else if (ld_valid & (ld_sel == `NTBMS_LD_DS3))
    begin
      ds3_atype_r <= ld_data[`NTBMS_SETUP_ATYPE_HI:`NTBMS_SETUP_ATYPE_LO];
      ds3_pf_r <= ld_data[`NTBMS_SETUP_PF_BIT];
      ds3_size_r <= ld_data[`NTBMS_SETUP_SIZE_HI:`NTBMS_SETUP_SIZE_LO];
      ds3_en_r <= ld_data[`NTBMS_SETUP_EN_BIT];
    end
  end

  // Window 3 upper setup, bus read/write
  always @(posedge core_clk)
  begin
    if (soft_clr & hot_clears(CLS_UPPER) | sys_rst)
      ds3_upper_r <= `NTBMS_RST_UPPER;
    else if (wr_ds3_up)
      ds3_upper_r <= cls_write(CLS_UPPER, ds3_upper_r, acc_wdata, acc_bm);
  end

  // Upstream window 3 setup: size and prefetch by bus, type by loader only
  always @(posedge core_clk)
  begin
    if (soft_clr & hot_clears(CLS_US3) | sys_rst)
    begin
      us3_atype_r <= `NTBMS_RST_ATYPE_US;
      us3_pf_r <= 1'b0;
      us3_size_r <= `NTBMS_RST_SIZE_US;
    end
    else
    begin
      if (ld_valid & (ld_sel == `NTBMS_LD_US3))
        us3_atype_r <= ld_data[`NTBMS_SETUP_ATYPE_HI:`NTBMS_SETUP_ATYPE_LO];
      if (wr_us3)
      begin
        us3_pf_r <= acc_bm[`NTBMS_SETUP_PF_BIT] ?
                    acc_wdata[`NTBMS_SETUP_PF_BIT] : us3_pf_r;
        us3_size_r <= us3_new[`NTBMS_XBASE_HI:`NTBMS_XBASE_LO];
      end
    end
  end

  // Window summaries for the BAR decoders, registered
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      ds2_bar_mask <= 32'h0000_0000;
      ds3_bar_mask <= 32'h0000_0000;
      ds3_upper_mask <= 32'h0000_0000;
      us3_bar_mask <= 32'h0000_0000;
      win_en <= 4'h0;
      win_prefetch <= 3'h0;
      win_is64 <= 3'h0;
    end
    else
    begin
      // Bit 31 of a 32-bit base is always part of the base
      ds2_bar_mask <= {1'b1, ds2_size_r, 12'h000};
      ds3_bar_mask <= {1'b1, ds3_size_r, 12'h000};
      ds3_upper_mask <= {1'b0, ds3_upper_r[30:0]};
      us3_bar_mask <= {us3_size_r, 12'h000};
      win_en <= {ds3_upper_r[`NTBMS_UPPER_EN_BIT], 1'b1, ds3_en_r, ds2_en_r};
      win_prefetch <= {us3_pf_r, ds3_pf_r, ds2_pf_r};
      win_is64 <= {us3_atype_r == `NTBMS_ATYPE_64, ds3_atype_r == `NTBMS_ATYPE_64,
                   ds2_atype_r == `NTBMS_ATYPE_64};
    end
  end

  // Per-window translation
  wire [63:0] xl_mask;
  wire [63:0] xl_base;
  wire [1:0] xl_en;
  assign xl_mask = {{1'b1, ds3_size_r, 12'h000}, {1'b1, ds2_size_r, 12'h000}};
  assign xl_base = {ds3_xbase_v, ds2_xbase_v};
  assign xl_en = {ds3_en_r, ds2_en_r};

  genvar gi;
  generate
    for (gi = 0; gi < 2; gi = gi + 1)
    begin : g_win
      ntbms_xlate u_xlate
      (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .win_en(xl_en[gi]),
        .win_mask(xl_mask[gi*32 +: 32]),
        .win_base(xl_base[gi*32 +: 32]),
        .req_hit(ds_hit[gi]),
        .req_addr(ds_addr[gi*32 +: 32]),
        .out_valid(ds_out_valid[gi]),
        .out_addr(ds_out_addr[gi*32 +: 32])
      );
    end
  endgenerate

endmodule // ntbms_csr

//--- verilog/ntbms_regs.vh
// Register offsets, field positions, reset values and access classes of the window setup CSRs
`ifndef NTBMS_REGS_VH
`define NTBMS_REGS_VH

// Word offsets (byte addresses)
`define NTBMS_OFF_RSVD0 12'h000
`define NTBMS_OFF_RSVD1 12'h004
`define NTBMS_OFF_DS2_XBASE 12'h008
`define NTBMS_OFF_DS2_SETUP 12'h00C
`define NTBMS_OFF_DS3_XBASE 12'h010
`define NTBMS_OFF_DS3_SETUP 12'h014
`define NTBMS_OFF_DS3_UPPER 12'h018
`define NTBMS_OFF_RSVD_LO 12'h01C
`define NTBMS_OFF_RSVD_HI 12'h030
`define NTBMS_OFF_US3_SETUP 12'h034

// Setup register field positions
`define NTBMS_SETUP_TYPE_BIT 0
`define NTBMS_SETUP_ATYPE_HI 2
`define NTBMS_SETUP_ATYPE_LO 1
`define NTBMS_SETUP_PF_BIT 3
`define NTBMS_SETUP_RSVD_HI 11
`define NTBMS_SETUP_RSVD_LO 4
`define NTBMS_SETUP_SIZE_HI 30
`define NTBMS_SETUP_SIZE_LO 12
`define NTBMS_SETUP_EN_BIT 31
`define NTBMS_XBASE_HI 31
`define NTBMS_XBASE_LO 12
`define NTBMS_UPPER_EN_BIT 31

// Reset values
`define NTBMS_RST_XBASE 20'h0_0000
`define NTBMS_RST_SIZE_DS 19'h0_0000
`define NTBMS_RST_SIZE_US 20'h0_0000
`define NTBMS_RST_ATYPE_DS 2'h0
`define NTBMS_RST_ATYPE_US 2'h1
`define NTBMS_RST_UPPER 32'h0000_0000

// Address type encodings
`define NTBMS_ATYPE_32 2'h0
`define NTBMS_ATYPE_64 2'h1

// Field access classes
`define NTBMS_CLS_RO 3'h0
`define NTBMS_CLS_ROS 3'h1
`define NTBMS_CLS_RW 3'h2
`define NTBMS_CLS_RWC 3'h3
`define NTBMS_CLS_RWS 3'h4
`define NTBMS_CLS_RWCS 3'h5

// Setup loader targets
`define NTBMS_LD_DS2 2'h0
`define NTBMS_LD_DS3 2'h1
`define NTBMS_LD_US3 2'h2

`endif

//--- verilog/ntbms_xlate.v
// Downstream window address translator: swaps sized upper bits for the translated base
`timescale 1ns/1ps
`include "ntbms_regs.vh"

module ntbms_xlate
(
  // Clock and reset
  input wire core_clk,
  input wire sys_rst,
  // Window state from the CSRs
  input wire win_en,
  input wire [31:0] win_mask,
  input wire [31:0] win_base,
  // Incoming transaction
  input wire req_hit,
  input wire [31:0] req_addr,
  // Translated result
  output reg out_valid,
  output reg [31:0] out_addr
);

  wire take;
  wire [31:0] swapped;

  // A disabled window never claims a hit
  assign take = req_hit & win_en;
  // Masked bits from base, offset bits kept
  assign swapped = (win_base & win_mask) | (req_addr & ~win_mask);

  // Registered so the result is glitch free at the port
  always @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      out_valid <= 1'b0;
      out_addr <= 32'h0000_0000;
    end
    else
    begin
      out_valid <= take;
      out_addr <= take ? swapped : req_addr;
    end
  end

endmodule // ntbms_xlate
